// File: verilog/slc_host_end.sv
// Link controller: AXI4-Lite registers, setup sequencer and command FIFO
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module slc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } slc_fifo_st_t;

  slc_fifo_st_t st_r;
  slc_fifo_st_t st_nxt;
  logic push;
  logic pop;

  assign o_in_ready = (st_r.cnt != FULL);
  assign o_out_valid = (st_r.cnt != '0);
  assign o_out_data = st_r.mem[st_r.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = i_in_data;
      st_nxt.wp = (st_r.wp == LAST) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == LAST) ? '0 : st_r.rp + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// How it works
// [RULE_01] Refuse setups whose lane rate leaves the range
// [RULE_02] Top band lane rates load nibble three
// [RULE_03] Middle band lane rates load nibble zero
// [RULE_04] Lower band lane rates load nibble one
// [RULE_05] Lowest band lane rates load nibble five
// [RULE_06] Output sample rate is ADC rate over decimation
// [RULE_07] One octet frames: K is 20 to 32; the code also refuses any K here that is not a multiple of four
// [RULE_08] Two octet frames: K multiple of four, 12-32
// [RULE_09] Four octet frames: K multiple of four, 8-32
// [RULE_10] Code 13h, 16-bit: one lane, four converters
// [RULE_11] Code 49h: two lanes, two converters, F two
// [RULE_12] Lane rate is M*N'*10/8*fout over L
// [RULE_13] Power down, code, details, rate, power up
// [RULE_14] Unsupported code keeps previous link parameters
module slc_host_end #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // AXI4-Lite slave
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [7:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Configuration port to the device
  slc_cfg_if.host cfg,
  // Status
  output logic o_busy,
  output logic o_done
);
  import slc_pkg::*;

  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] code;
    logic [7:0] cfgw;
    logic [7:0] klen;
    logic [31:0] adc;
    logic [31:0] rate;
    logic [3:0] band;
    logic done;
    logic rate_err;
    logic [7:0] dstat;
    slc_state_t st;
    logic [2:0] idx;
  } slc_host_st_t;

  slc_host_st_t st_r;
  slc_host_st_t st_nxt;
  logic f_in_valid;
  logic f_in_ready;
  logic [23:0] f_in_data;
  logic f_out_valid;
  logic [23:0] f_out_data;
  slc_link_t p;
  logic [31:0] rd_word;

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Setup write list in the order the link must see it
  function automatic logic [23:0] seq_word(input logic [2:0] idx,
                                           input slc_host_st_t s);
    logic [7:0] c;
    c = s.cfgw;
    c[SLC_CTRL_PD_BIT] = (idx != SLC_SEQ_LAST);
    case (idx)
      3'd1: return {SLC_QUICK_OFS, s.code};
      3'd2: return {SLC_KLEN_OFS, s.klen};
      3'd3: return {SLC_LRC_OFS, s.band, 4'h0};
      default: return {SLC_CTRL_OFS, c};
    endcase
  endfunction

  // ****************************************************
  // Command FIFO toward the device
  // ****************************************************
  slc_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(f_in_valid),
    .i_in_data(f_in_data),
    .o_in_ready(f_in_ready),
    .o_out_valid(f_out_valid),
    .o_out_data(f_out_data),
    .i_out_ready(cfg.ready)
  );

  assign f_in_valid = (st_r.st == SLC_PUSH);
  assign f_in_data = seq_word(st_r.idx, st_r); // [RULE_13]
  assign cfg.wr = f_out_valid;
  assign cfg.rd = (st_r.st == SLC_READ);
  assign cfg.addr = (st_r.st == SLC_READ) ? SLC_STAT_OFS :
    f_out_data[23:8];
  assign cfg.wdata = f_out_data[7:0];

  always_comb begin
    rd_word = 32'h0000_0000;
    case (i_s_axi_araddr)
      SLC_H_CODE_OFS: rd_word = {24'h0, st_r.code};
      SLC_H_CFG_OFS: rd_word = {24'h0, st_r.cfgw};
      SLC_H_KLEN_OFS: rd_word = {24'h0, st_r.klen};
      SLC_H_ADC_OFS: rd_word = st_r.adc;
      SLC_H_STAT_OFS: rd_word = {16'h0, st_r.dstat, 5'h0,
        st_r.rate_err, st_r.done, (st_r.st != SLC_IDLE)};
      SLC_H_RATE_OFS: rd_word = st_r.rate;
      SLC_H_BAND_OFS: rd_word = {28'h0, st_r.band};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ****************************************************
  // Bus slave and sequencer
  // ****************************************************
  always_comb begin
    st_nxt = st_r;
    p = slc_decode(st_r.code, st_r.cfgw[SLC_CTRL_N8_BIT]);
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = i_s_axi_wdata;
      st_nxt.wstrb = i_s_axi_wstrb;
    end
    if (st_r.bvalid && i_s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = SLC_RESP_OK;
      // Setup values are frozen while a sequence runs
      case (st_r.awaddr)
        SLC_H_CMD_OFS:
          if (st_r.st == SLC_IDLE && st_r.wstrb[0] && st_r.wdata[0]) begin
            st_nxt.st = SLC_CALC;
            st_nxt.done = 1'b0;
            st_nxt.rate_err = 1'b0;
          end
        SLC_H_CODE_OFS:
          if (st_r.st == SLC_IDLE) begin
            st_nxt.code = 8'(strb_merge({24'h0, st_r.code}, st_r.wdata,
              st_r.wstrb));
          end
        SLC_H_CFG_OFS:
          if (st_r.st == SLC_IDLE) begin
            st_nxt.cfgw = 8'(strb_merge({24'h0, st_r.cfgw}, st_r.wdata,
              st_r.wstrb));
          end
        SLC_H_KLEN_OFS:
          if (st_r.st == SLC_IDLE) begin
            st_nxt.klen = 8'(strb_merge({24'h0, st_r.klen}, st_r.wdata,
              st_r.wstrb));
          end
        SLC_H_ADC_OFS:
          if (st_r.st == SLC_IDLE) begin
            st_nxt.adc = strb_merge(st_r.adc, st_r.wdata, st_r.wstrb);
          end
        default: st_nxt.bresp = SLC_RESP_ERR;
      endcase
    end
    if (st_r.rvalid && i_s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = (i_s_axi_araddr > SLC_H_BAND_OFS ||
        i_s_axi_araddr[1:0] != 2'b00) ? SLC_RESP_ERR : SLC_RESP_OK;
    end
    unique case (st_r.st)
      SLC_IDLE: ;
      SLC_CALC: begin
        st_nxt.rate = slc_lane_rate(p, st_r.cfgw[SLC_CTRL_N8_BIT],
          st_r.adc, st_r.cfgw[SLC_CTRL_DCM_LSB +: 3]); // [RULE_06] [RULE_12]
        st_nxt.band = slc_band(st_nxt.rate); // [RULE_02] [RULE_03] [RULE_04] [RULE_05]
        st_nxt.idx = 3'd0;
        if (!p.ok || !slc_rate_ok(st_nxt.rate) ||
            !slc_k_ok(p.f, st_r.klen)) begin // [RULE_01] [RULE_07] [RULE_08] [RULE_09]
          st_nxt.rate_err = 1'b1;
          st_nxt.done = 1'b1;
          st_nxt.st = SLC_IDLE;
        end else begin
          st_nxt.st = SLC_PUSH;
        end
      end
      SLC_PUSH:
        if (f_in_ready) begin
          st_nxt.idx = st_r.idx + 3'd1;
          if (st_r.idx == SLC_SEQ_LAST) st_nxt.st = SLC_DRAIN; // [RULE_13]
        end
      SLC_DRAIN:
        if (!f_out_valid) st_nxt.st = SLC_READ;
      SLC_READ:
        if (cfg.ready) st_nxt.st = SLC_RWAIT;
      SLC_RWAIT:
        if (cfg.rvalid) begin
          st_nxt.dstat = cfg.rdata;
          st_nxt.done = 1'b1;
          st_nxt.st = SLC_IDLE;
        end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.code <= SLC_QUICK_RST;
      st_r.klen <= SLC_KLEN_RST;
      st_r.st <= SLC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_s_axi_awready = !st_r.aw_have && !st_r.bvalid;
  assign o_s_axi_wready = !st_r.w_have && !st_r.bvalid;
  assign o_s_axi_bvalid = st_r.bvalid;
  assign o_s_axi_bresp = st_r.bresp;
  assign o_s_axi_arready = !st_r.rvalid;
  assign o_s_axi_rvalid = st_r.rvalid;
  assign o_s_axi_rdata = st_r.rdata;
  assign o_s_axi_rresp = st_r.rresp;
  assign o_busy = (st_r.st != SLC_IDLE);
  assign o_done = st_r.done;
endmodule

// File: verilog/slc_pkg.sv
// Shared constants, types and decode functions for the link setup blocks
package slc_pkg;

  // ****************************************************
  // Device register offsets and reset values
  // ****************************************************
  localparam logic [15:0] SLC_LRC_OFS = 16'h056e;
  localparam logic [15:0] SLC_QUICK_OFS = 16'h0570;
  localparam logic [15:0] SLC_KLEN_OFS = 16'h0571;
  localparam logic [15:0] SLC_CTRL_OFS = 16'h0572;
  localparam logic [15:0] SLC_STAT_OFS = 16'h0573;
  localparam logic [7:0] SLC_LRC_RST = 8'h00;
  localparam logic [7:0] SLC_QUICK_RST = 8'h49;
  localparam logic [7:0] SLC_KLEN_RST = 8'h20;
  localparam logic [7:0] SLC_CTRL_RST = 8'h01;
  localparam int SLC_CTRL_PD_BIT = 0;
  localparam int SLC_CTRL_N8_BIT = 1;
  localparam int SLC_CTRL_DCM_LSB = 4;
  localparam int SLC_LRC_BAND_LSB = 4;
  localparam int SLC_STAT_CODE_BIT = 0;
  localparam int SLC_STAT_K_BIT = 1;
  localparam int SLC_STAT_BAND_BIT = 2;

  // ****************************************************
  // Lane rate limits (kbps) and band codes
  // ****************************************************
  localparam logic [31:0] SLC_RATE_MIN_KBPS = 32'd1687500;
  localparam logic [31:0] SLC_RATE_MAX_KBPS = 32'd15000000;
  localparam logic [31:0] SLC_RATE_TOP_KBPS = 32'd13500000;
  localparam logic [31:0] SLC_RATE_MID_KBPS = 32'd6750000;
  localparam logic [31:0] SLC_RATE_LOW_KBPS = 32'd3375000;
  localparam logic [3:0] SLC_BAND_TOP = 4'h3;
  localparam logic [3:0] SLC_BAND_MID = 4'h0;
  localparam logic [3:0] SLC_BAND_LOW = 4'h1;
  localparam logic [3:0] SLC_BAND_MIN = 4'h5;
  localparam logic [47:0] SLC_LINE_BITS = 48'd10;
  localparam logic [47:0] SLC_OCTET_BITS = 48'd8;
  localparam logic [7:0] SLC_K_MAX = 8'd32;

  // ****************************************************
  // Controller register offsets (AXI4-Lite byte addresses)
  // ****************************************************
  localparam logic [7:0] SLC_H_CMD_OFS = 8'h00;
  localparam logic [7:0] SLC_H_CODE_OFS = 8'h04;
  localparam logic [7:0] SLC_H_CFG_OFS = 8'h08;
  localparam logic [7:0] SLC_H_KLEN_OFS = 8'h0c;
  localparam logic [7:0] SLC_H_ADC_OFS = 8'h10;
  localparam logic [7:0] SLC_H_STAT_OFS = 8'h14;
  localparam logic [7:0] SLC_H_RATE_OFS = 8'h18;
  localparam logic [7:0] SLC_H_BAND_OFS = 8'h1c;
  localparam logic [2:0] SLC_SEQ_LAST = 3'd4;
  localparam logic [1:0] SLC_RESP_OK = 2'b00;
  localparam logic [1:0] SLC_RESP_ERR = 2'b10;

  typedef struct packed {
    logic ok;
    logic [1:0] l;
    logic [2:0] m;
    logic [3:0] f;
    logic [3:0] s;
  } slc_link_t;
  localparam slc_link_t SLC_LINK_RST = '{1'b1, 2'd2, 3'd2, 4'd2, 4'd1};

  typedef enum logic [2:0] {
    SLC_IDLE, SLC_CALC, SLC_PUSH, SLC_DRAIN, SLC_READ, SLC_RWAIT
  } slc_state_t;

  function automatic slc_link_t slc_mk(input int l, input int m,
                                       input int f, input int s);
    slc_link_t r;
    r.ok = 1'b1;
    r.l = 2'(l);
    r.m = 3'(m);
    r.f = 4'(f);
    r.s = 4'(s);
    return r;
  endfunction

  // Quick code to L/M/F/S for the selected container width
  function automatic slc_link_t slc_decode(input logic [7:0] code,
                                           input logic n8);
    slc_link_t r;
    r = '0;
    case ({n8, code})
      {1'b0, 8'h01}: r = slc_mk(1, 1, 2, 1);
      {1'b0, 8'h40}: r = slc_mk(2, 1, 1, 1);
      {1'b0, 8'h41}: r = slc_mk(2, 1, 2, 2);
      {1'b0, 8'h0a}: r = slc_mk(1, 2, 4, 1);
      {1'b0, 8'h49}: r = slc_mk(2, 2, 2, 1);
      {1'b0, 8'h13}: r = slc_mk(1, 4, 8, 1);
      {1'b0, 8'h52}: r = slc_mk(2, 4, 4, 1);
      {1'b1, 8'h00}: r = slc_mk(1, 1, 1, 1);
      {1'b1, 8'h01}: r = slc_mk(1, 1, 2, 2);
      {1'b1, 8'h40}: r = slc_mk(2, 1, 1, 2);
      {1'b1, 8'h41}: r = slc_mk(2, 1, 2, 4);
      {1'b1, 8'h42}: r = slc_mk(2, 1, 4, 8);
      {1'b1, 8'h09}: r = slc_mk(1, 2, 2, 1);
      {1'b1, 8'h48}: r = slc_mk(2, 2, 1, 1);
      {1'b1, 8'h49}: r = slc_mk(2, 2, 2, 2);
      default: r = '0;
    endcase
    return r;
  endfunction

  // Lane rate in kbps from the ADC rate in ksps
  function automatic logic [31:0] slc_lane_rate(input slc_link_t p,
                                                input logic n8,
                                                input logic [31:0] adc,
                                                input logic [2:0] dcm);
    logic [47:0] fout;
    logic [47:0] prod;
    logic [47:0] div;
    fout = {16'h0000, adc >> dcm};
    prod = fout * 48'(p.m) * (n8 ? 48'd8 : 48'd16) * SLC_LINE_BITS;
    div = SLC_OCTET_BITS * ((p.l == 2'd0) ? 48'd1 : 48'(p.l));
    prod = prod / div;
    return (prod[47:32] != 16'h0000) ? 32'hffff_ffff : prod[31:0];
  endfunction

  function automatic logic [3:0] slc_band(input logic [31:0] rate);
    if (rate >= SLC_RATE_TOP_KBPS) return SLC_BAND_TOP;
    if (rate >= SLC_RATE_MID_KBPS) return SLC_BAND_MID;
    if (rate >= SLC_RATE_LOW_KBPS) return SLC_BAND_LOW;
    return SLC_BAND_MIN;
  endfunction

  function automatic logic slc_rate_ok(input logic [31:0] rate);
    return (rate >= SLC_RATE_MIN_KBPS) && (rate <= SLC_RATE_MAX_KBPS);
  endfunction

  // Multiframe length check against octets per frame
  function automatic logic slc_k_ok(input logic [3:0] f,
                                    input logic [7:0] k);
    logic [7:0] kmin;
    kmin = (f == 4'd1) ? 8'd20 : (f == 4'd2) ? 8'd12 : 8'd8;
    return (k[1:0] == 2'b00) && (k <= SLC_K_MAX) && (k >= kmin);
  endfunction

endpackage

// File: verilog/slc_cfg_if.sv
// Configuration port between the link controller and the device end
`timescale 1ns/10ps
interface slc_cfg_if;
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic ready;
  logic [7:0] rdata;
  logic rvalid;

  modport dev (
    input wr, rd, addr, wdata,
    output ready, rdata, rvalid
  );

  modport host (
    output wr, rd, addr, wdata,
    input ready, rdata, rvalid
  );
endinterface

// File: verilog/slc_dev_end.sv
// Device end: link registers, quick code decode and lane rate derivation
`timescale 1ns/10ps
module slc_dev_end (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Configuration port
  slc_cfg_if.dev cfg,
  // Converter side
  input wire logic [31:0] i_adc_rate_ksps,
  // Link parameters
  output slc_pkg::slc_link_t o_link_params,
  output logic [31:0] o_lane_rate_kbps,
  output logic [7:0] o_frames_per_multi,
  output logic o_container_8b,
  output logic o_link_up
);
  import slc_pkg::*;

  typedef struct packed {
    logic [7:0] lrc;
    logic [7:0] quick;
    logic [7:0] klen;
    logic [7:0] ctrl;
    slc_link_t active;
    logic [31:0] rate;
    logic busy;
    logic rvalid;
    logic [7:0] rdata;
  } slc_dev_st_t;

  slc_dev_st_t st_r;
  slc_dev_st_t st_nxt;
  slc_link_t dec;
  logic n8;
  logic [7:0] stat;

  assign n8 = st_r.ctrl[SLC_CTRL_N8_BIT];

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.busy = 1'b0;
    st_nxt.rvalid = 1'b0;
    dec = slc_decode(st_r.quick, n8); // [RULE_10] [RULE_11]
    stat = 8'h00;
    stat[SLC_STAT_CODE_BIT] = dec.ok;
    stat[SLC_STAT_K_BIT] = slc_k_ok(st_r.active.f, st_r.klen); // [RULE_07] [RULE_08] [RULE_09]
    stat[SLC_STAT_BAND_BIT] = slc_rate_ok(st_r.rate) &&
      (st_r.lrc[SLC_LRC_BAND_LSB +: 4] == slc_band(st_r.rate));
    // One idle cycle after each write lets the decode settle
    if (cfg.wr && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      case (cfg.addr)
        SLC_LRC_OFS: st_nxt.lrc = cfg.wdata;
        SLC_QUICK_OFS: st_nxt.quick = cfg.wdata;
        SLC_KLEN_OFS: st_nxt.klen = cfg.wdata;
        SLC_CTRL_OFS: st_nxt.ctrl = cfg.wdata;
        default: ;
      endcase
    end else if (cfg.rd && !st_r.busy) begin
      st_nxt.rvalid = 1'b1;
      case (cfg.addr)
        SLC_LRC_OFS: st_nxt.rdata = st_r.lrc;
        SLC_QUICK_OFS: st_nxt.rdata = st_r.quick;
        SLC_KLEN_OFS: st_nxt.rdata = st_r.klen;
        SLC_CTRL_OFS: st_nxt.rdata = st_r.ctrl;
        SLC_STAT_OFS: st_nxt.rdata = stat;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // Unsupported code keeps the last good parameters
    if (dec.ok) begin
      st_nxt.active = dec; // [RULE_14]
    end
    st_nxt.rate = slc_lane_rate(st_r.active, n8, i_adc_rate_ksps,
      st_r.ctrl[SLC_CTRL_DCM_LSB +: 3]); // [RULE_06] [RULE_12]
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r.lrc <= SLC_LRC_RST;
      st_r.quick <= SLC_QUICK_RST;
      st_r.klen <= SLC_KLEN_RST;
      st_r.ctrl <= SLC_CTRL_RST;
      st_r.active <= SLC_LINK_RST;
      st_r.rate <= 32'h0000_0000;
      st_r.busy <= 1'b0;
      st_r.rvalid <= 1'b0;
      st_r.rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign cfg.ready = !st_r.busy;
  assign cfg.rvalid = st_r.rvalid;
  assign cfg.rdata = st_r.rdata;
  assign o_link_params = st_r.active;
  assign o_lane_rate_kbps = st_r.rate;
  assign o_frames_per_multi = st_r.klen;
  assign o_container_8b = n8;
  assign o_link_up = !st_r.ctrl[SLC_CTRL_PD_BIT] &&
    slc_k_ok(st_r.active.f, st_r.klen); // [RULE_07] [RULE_08] [RULE_09]
endmodule

// File: verification/slc_cfg_properties.sv
// Checker for the configuration port between the two link ends
`timescale 1ns/10ps
module slc_cfg_properties (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Configuration port
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ready,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  import slc_pkg::*;
  logic pd_r;
  logic band_r;
  logic tw;
  assign tw = wr && ready;
  // ****
  // Setup order tracking
  // ****
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pd_r <= 1'b1;
      band_r <= 1'b0;
    end else if (tw && addr == SLC_CTRL_OFS) begin
      pd_r <= wdata[0];
      band_r <= 1'b0;
    end else if (tw && addr == SLC_LRC_OFS) begin
      band_r <= 1'b1;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // ****
  // Properties
  // ****
  property p_wr_gap;
    tw |=> !ready ##1 ready;
  endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write gap");
  property p_rd_ans;
    rd && ready && !wr |=> rvalid ##1 !rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer");
  property p_hold;
    (wr || rd) && !ready |=> (wr || rd) && $stable(addr);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  // Link details only while powered down
  property p_pd_first;
    tw && (addr == SLC_QUICK_OFS || addr == SLC_KLEN_OFS ||
      addr == SLC_LRC_OFS) |-> pd_r;
  endproperty
  a_pd_first: assert property (p_pd_first) else $error("not down");
  property p_up_last;
    tw && addr == SLC_CTRL_OFS && !wdata[0] |-> band_r;
  endproperty
  a_up_last: assert property (p_up_last) else $error("early up");
  property p_band;
    tw && addr == SLC_LRC_OFS |->
      wdata[3:0] == 4'h0 && wdata[7:4] inside {4'h3, 4'h0, 4'h1, 4'h5};
  endproperty
  a_band: assert property (p_band) else $error("band code");
  property p_k;
    tw && addr == SLC_KLEN_OFS |->
      wdata[1:0] == 2'b00 && wdata >= 8'd8 && wdata <= SLC_K_MAX;
  endproperty
  a_k: assert property (p_k) else $error("frame count");
  property p_rd_stat;
    rd && !wr |-> addr == SLC_STAT_OFS;
  endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("read addr");
endmodule

// File: verification/testbench.sv
// Testbench: AXI4-Lite setup runs through both link ends
`timescale 1ns/10ps
module testbench;
  import slc_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, kfm;
  logic [31:0] wdata = 32'h0, adc = 32'h0, rdata, rate;
  logic awready, wready, bvalid, arready, rvalid, busy, done, c8, up;
  logic [1:0] bresp, rresp;
  slc_link_t par;
  logic [13:0] last = 14'h3221;
  int errors = 0, check_count = 0;
  slc_cfg_if cfg_bus ();
  slc_dev_end slc_dev_end_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .cfg(cfg_bus.dev), .i_adc_rate_ksps(adc), .o_link_params(par),
    .o_lane_rate_kbps(rate), .o_frames_per_multi(kfm),
    .o_container_8b(c8), .o_link_up(up));
  slc_host_end slc_host_end_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .cfg(cfg_bus.host), .o_busy(busy),
    .o_done(done));
  slc_cfg_properties slc_cfg_properties_i (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .wr(cfg_bus.wr), .rd(cfg_bus.rd),
    .addr(cfg_bus.addr), .wdata(cfg_bus.wdata), .ready(cfg_bus.ready),
    .rdata(cfg_bus.rdata), .rvalid(cfg_bus.rvalid));
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  always @(negedge i_ref_clk)
    if (busy) chk({31'h0, par.ok}, 32'h1, "keep");
  // ****
  // Tasks
  // ****
  task results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h saw %h", n, e, s);
    end
  endtask
  task tick(input int n);
    if (n > 100) begin
      errors++;
      results();
    end
  endtask
  // Handshakes judged at negedge, where both sides are settled
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw;
    r = 2'b11;
    @(posedge i_ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; r === 2'b11; n++) begin
      @(negedge i_ref_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      if (bvalid) r = bresp;
      @(posedge i_ref_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (r !== 2'b11) bready <= 1'b0;
      tick(n);
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ta;
    r = 2'b11;
    @(posedge i_ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; r === 2'b11; n++) begin
      @(negedge i_ref_clk);
      ta = arvalid && arready;
      d = rdata;
      if (rvalid) r = rresp;
      @(posedge i_ref_clk);
      if (ta) arvalid <= 1'b0;
      if (r !== 2'b11) rready <= 1'b0;
      tick(n);
    end
  endtask
  // One setup run; p of zero means the setup must be refused
  task automatic run(input logic [7:0] c, input logic [7:0] g,
    input logic [31:0] f, input logic [7:0] k, input logic [13:0] p,
    input logic [31:0] lr, input logic [3:0] b);
    logic [31:0] d;
    logic [1:0] r;
    adc <= f;
    axw(SLC_H_CODE_OFS, {24'h0, c}, r);
    axw(SLC_H_CFG_OFS, {24'h0, g}, r);
    axw(SLC_H_KLEN_OFS, {24'h0, k}, r);
    axw(SLC_H_ADC_OFS, f, r);
    axw(SLC_H_CMD_OFS, 32'h1, r);
    d = 32'h0;
    for (int n = 0; d[1:0] !== 2'b10; n++) begin
      axr(SLC_H_STAT_OFS, d, r);
      tick(n);
    end
    chk({30'h0, busy, done}, 32'h1, "idle");
    chk({31'h0, d[2]}, {31'h0, p == 14'h0}, "refused");
    if (p != 14'h0) begin
      last = p;
      chk({24'h0, d[15:8]}, 32'h7, "dev_status");
      axr(SLC_H_RATE_OFS, d, r);
      chk(d, lr, "host_rate");
      axr(SLC_H_BAND_OFS, d, r);
      chk(d, {28'h0, b}, "band");
      chk(rate, lr, "lane_rate");
      chk({24'h0, kfm}, {24'h0, k}, "k");
      chk({30'h0, c8, up}, {30'h0, g[1], 1'b1}, "n8_up");
    end
    chk({18'h0, par}, {18'h0, last}, "params");
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge i_ref_clk);
    chk({18'h0, par}, 32'h3221, "rst_params");
    chk({31'h0, up}, 32'h0, "rst_up");
    i_rst_b <= 1'b1;
    axr(SLC_H_CODE_OFS, d, r);
    chk(d, 32'h49, "rst_code");
    axr(SLC_H_KLEN_OFS, d, r);
    chk(d, 32'h20, "rst_k");
    axw(SLC_H_STAT_OFS, 32'h0, r);
    chk({30'h0, r}, {30'h0, SLC_RESP_ERR}, "ro_wr");
    axw(8'h20, 32'h0, r);
    chk({30'h0, r}, {30'h0, SLC_RESP_ERR}, "map_wr");
    axr(8'h40, d, r);
    chk({30'h0, r}, {30'h0, SLC_RESP_ERR}, "map_rd");
    run(8'h13, 8'h20, 500000, 32, 14'h2c81, 10000000, 4'h0);
    run(8'h49, 8'h00, 675000, 32, 14'h3221, 13500000, 4'h3);
    run(8'h49, 8'h00, 750000, 32, 14'h3221, 15000000, 4'h3);
    run(8'h0a, 8'h00, 168750, 8, 14'h2a41, 6750000, 4'h0);
    run(8'h48, 8'h02, 337500, 20, 14'h3211, 3375000, 4'h1);
    run(8'h42, 8'h02, 400000, 8, 14'h3148, 2000000, 4'h5);
    run(8'h49, 8'h12, 800000, 12, 14'h3222, 4000000, 4'h1);
    run(8'h40, 8'h02, 337500, 20, 14'h3112, 1687500, 4'h5);
    run(8'h01, 8'h00, 400000, 12, 14'h2921, 8000000, 4'h0);
    run(8'h40, 8'h00, 500000, 24, 14'h3111, 5000000, 4'h1);
    run(8'h41, 8'h00, 1000000, 16, 14'h3122, 10000000, 4'h0);
    run(8'h52, 8'h00, 350000, 28, 14'h3441, 14000000, 4'h3);
    run(8'h00, 8'h02, 300000, 28, 14'h2911, 3000000, 4'h5);
    run(8'h01, 8'h02, 700000, 16, 14'h2922, 7000000, 4'h0);
    run(8'h41, 8'h02, 1000000, 20, 14'h3124, 5000000, 4'h1);
    run(8'h09, 8'h02, 600000, 32, 14'h2a21, 12000000, 4'h0);
    run(8'h13, 8'h10, 500000, 32, 14'h0, 0, 4'h0);
    run(8'h40, 8'h02, 337499, 20, 14'h0, 0, 4'h0);
    run(8'h48, 8'h02, 400000, 16, 14'h0, 0, 4'h0);
    run(8'h49, 8'h00, 500000, 8, 14'h0, 0, 4'h0);
    run(8'h42, 8'h02, 400000, 10, 14'h0, 0, 4'h0);
    run(8'h13, 8'h02, 400000, 32, 14'h0, 0, 4'h0);
    results();
  end
endmodule
